// ### rtl/swdrop_pkg.sv
// Package: register map, field layout and types of the drop statistics block
package swdrop_pkg;

   localparam int NUM_PORTS = 3;

   // Register indices; byte address is four times the index
   localparam logic [15:0] PORT0_DROP_CNT_IDX = 16'h1c16;
   localparam logic [15:0] PORT1_DROP_CNT_IDX = 16'h1c17;
   localparam logic [15:0] PORT2_DROP_CNT_IDX = 16'h1c18;
   localparam logic [15:0] IRQ_MASK_IDX       = 16'h1c20;
   localparam logic [15:0] IRQ_PENDING_IDX    = 16'h1c21;
   localparam logic [15:0] IRQ_STATUS_IDX     = 16'h1c22;
   localparam logic [15:0] IRQ_ENABLE_IDX     = 16'h1c23;
   localparam logic [15:0] IRQ_CLEAR_IDX      = 16'h1c24;

   // Field positions
   localparam int MASK_BIT       = 0;
   localparam int A_VALID_BIT    = 0;
   localparam int A_PORT_LSB     = 1;
   localparam int A_REASON_LSB   = 3;
   localparam int B_VALID_BIT    = 7;
   localparam int B_PORT_LSB     = 8;
   localparam int B_REASON_LSB   = 10;
   localparam int PENDING_WIDTH  = 14;

   // Event status bits (sticky status / enable / clear layout)
   localparam int EV_CAPTURE_BIT = 0;
   localparam int EV_LOST_BIT    = 1;
   localparam int EV_SAT_BIT     = 2;
   localparam int EV_WIDTH       = 3;

   // Reset values and counter saturation limit
   localparam logic [31:0] CNT_RESET      = 32'h0000_0000;
   localparam logic [31:0] CNT_MAX        = 32'hffff_ffff;
   localparam logic        MASK_RESET     = 1'b1;
   localparam logic [2:0]  EV_ENABLE_RST  = 3'h0;

   // Drop reason codes
   typedef enum logic [3:0] {
      RSN_BCAST_LEVEL  = 4'h0,
      RSN_RED          = 4'h1,
      RSN_NO_BUFFER    = 4'h2,
      RSN_NO_DESC      = 4'h3,
      RSN_NO_DEST      = 4'h4,
      RSN_RX_ERROR     = 4'h5,
      RSN_DROP_LEVEL   = 4'h6,
      RSN_YELLOW       = 4'h9
   } swdrop_reason_type;

   // Port code: 2'b11 never used
   typedef logic [1:0] swdrop_port_type;

   // One captured drop record
   typedef struct packed {
      swdrop_reason_type reason;
      swdrop_port_type   port;
      logic              valid;
   } swdrop_record_type;

   // Drop event from the datapath
   typedef struct packed {
      logic              valid;
      swdrop_reason_type reason;
      swdrop_port_type   port;
   } swdrop_event_type;

   // APB request
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } swdrop_apb_req_type;

endpackage

// ### rtl/swdrop_stats.sv
// Drop statistics counters, drop record capture and interrupt logic with APB slave
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps

// Function
// R01 - Per-port counter counts red/yellow rate drops
// R02 - Counters 32 bits, reset zero, clear on read
// R03 - Counter saturates at all ones
// R04 - Mask bit 0 blocks interrupt, resets one
// R05 - Mask never stops capture or pending bits
// R06 - Two independent records A and B
// R07 - Bit 0 is record A valid, read clears
// R08 - Record A reason in bits 6:3
// R09 - Record A port in bits 2:1
// R10 - Bit 7 is record B valid, read clears
// R11 - Record B reason 13:10, port 9:8
// R12 - Codes 0000, 0100: broadcast level, no destination
// R13 - Codes 0010, 0011, 0110: buffers, descriptors, level
// R14 - Codes 0001 red, 1001 yellow random drop
// R15 - Code 0101 rx error; other codes reserved
// R16 - Capture into A, else B, else discard
// R17 - Interrupt when record valid and unmasked
module swdrop_stats
   import swdrop_pkg::*;
(
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire swdrop_apb_req_type apb_req,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Drop events from the datapath
   input  wire swdrop_event_type   drop_event,
   input  wire logic [2:0]         rate_drop,
   // Interrupts
   output logic                    bm_irq,
   output logic                    irq
);

   logic                  access;
   logic                  rd_en;
   logic                  wr_en;
   logic [15:0]           reg_idx;
   logic                  addr_ok;
   logic                  aligned;
   logic [31:0]           cnt_q [NUM_PORTS];
   logic                  mask_q;
   swdrop_record_type     rec_a_q;
   swdrop_record_type     rec_b_q;
   logic [EV_WIDTH-1:0]   ev_status_q;
   logic [EV_WIDTH-1:0]   ev_enable_q;
   logic [EV_WIDTH-1:0]   ev_set;
   logic                  pending_rd;
   logic                  cap_a;
   logic                  cap_b;
   logic                  lost;
   logic [NUM_PORTS-1:0]  sat_hit;
   logic [31:0]           rdata_d;
   logic                  err_d;

   // Access phase lasts two cycles; pready goes high in its second cycle, one cycle after access
   assign access  = apb_req.psel & apb_req.penable & ~pready;
   assign reg_idx = apb_req.paddr[17:2];
   assign aligned = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr[31:18] == 14'h0000);
   assign rd_en   = access & ~apb_req.pwrite & addr_ok;
   assign wr_en   = access &  apb_req.pwrite & addr_ok;
   assign pending_rd = rd_en && (reg_idx == IRQ_PENDING_IDX);

   // Read mux and decode
   always_comb begin
      rdata_d = 32'h0000_0000;
      addr_ok = aligned;
      case (reg_idx)
         PORT0_DROP_CNT_IDX: rdata_d = cnt_q[0];
         PORT1_DROP_CNT_IDX: rdata_d = cnt_q[1];
         PORT2_DROP_CNT_IDX: rdata_d = cnt_q[2];
         IRQ_MASK_IDX:       rdata_d[MASK_BIT] = mask_q;
         IRQ_PENDING_IDX: begin
            rdata_d[A_VALID_BIT]                 = rec_a_q.valid;   // [R07]
            rdata_d[A_PORT_LSB +: 2]             = rec_a_q.port;    // [R09]
            rdata_d[A_REASON_LSB +: 4]           = rec_a_q.reason;  // [R08]
            rdata_d[B_VALID_BIT]                 = rec_b_q.valid;   // [R10]
            rdata_d[B_PORT_LSB +: 2]             = rec_b_q.port;    // [R11]
            rdata_d[B_REASON_LSB +: 4]           = rec_b_q.reason;  // [R11]
         end
         IRQ_STATUS_IDX:     rdata_d[EV_WIDTH-1:0] = ev_status_q;
         IRQ_ENABLE_IDX:     rdata_d[EV_WIDTH-1:0] = ev_enable_q;
         IRQ_CLEAR_IDX:      rdata_d = 32'h0000_0000;
         default:            addr_ok = 1'b0;
      endcase
   end

   assign err_d = access & ~addr_ok;

   // APB answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= access;
         pslverr <= err_d;
         if (access && !apb_req.pwrite) begin
            prdata <= addr_ok ? rdata_d : 32'h0000_0000;
         end
      end
   end

   // Per-port saturating clear-on-read counters
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_cnt
         logic [15:0] my_idx;
         logic        my_rd;
         assign my_idx = PORT0_DROP_CNT_IDX + 16'(p);
         assign my_rd  = rd_en && (reg_idx == my_idx);
         assign sat_hit[p] = rate_drop[p] && (cnt_q[p] == CNT_MAX - 32'h0000_0001) && !my_rd;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt_q[p] <= CNT_RESET;                              // [R02]
            end else if (my_rd) begin
               // Drop in the read cycle is kept as the first new count
               cnt_q[p] <= rate_drop[p] ? 32'h0000_0001 : CNT_RESET; // [R02]
            end else if (rate_drop[p] && cnt_q[p] != CNT_MAX) begin // [R03]
               cnt_q[p] <= cnt_q[p] + 32'h0000_0001;                // [R01]
            end
         end
      end
   endgenerate

   // Mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= MASK_RESET;                                      // [R04]
      end else if (wr_en && reg_idx == IRQ_MASK_IDX) begin
         mask_q <= apb_req.pwdata[MASK_BIT];                        // [R04]
      end
   end

   // Capture ignores the mask; a record freed by this read is free now
   assign cap_a = drop_event.valid && (!rec_a_q.valid || pending_rd);                  // [R05] [R16]
   assign cap_b = drop_event.valid && !cap_a && (!rec_b_q.valid || pending_rd);       // [R16]
   assign lost  = drop_event.valid && !cap_a && !cap_b;                                // [R16]

   // Reason codes pass through unchanged as 4-bit values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_a_q <= '0;
      end else if (cap_a) begin
         rec_a_q.valid  <= 1'b1;                                    // [R06] [R07]
         rec_a_q.reason <= drop_event.reason;                       // [R12] [R13] [R14] [R15]
         rec_a_q.port   <= drop_event.port;                         // [R09]
      end else if (pending_rd) begin
         rec_a_q <= '0;                                             // [R07] [R08]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_b_q <= '0;
      end else if (cap_b) begin
         rec_b_q.valid  <= 1'b1;                                    // [R06] [R10]
         rec_b_q.reason <= drop_event.reason;                       // [R11]
         rec_b_q.port   <= drop_event.port;                         // [R11]
      end else if (pending_rd) begin
         rec_b_q <= '0;                                             // [R10] [R11]
      end
   end

   // Sticky event status; set wins over write-one-to-clear
   assign ev_set[EV_CAPTURE_BIT] = cap_a | cap_b;
   assign ev_set[EV_LOST_BIT]    = lost;
   assign ev_set[EV_SAT_BIT]     = |sat_hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_status_q <= '0;
      end else begin
         if (wr_en && reg_idx == IRQ_CLEAR_IDX) begin
            ev_status_q <= (ev_status_q & ~apb_req.pwdata[EV_WIDTH-1:0]) | ev_set;
         end else begin
            ev_status_q <= ev_status_q | ev_set;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_enable_q <= EV_ENABLE_RST;
      end else if (wr_en && reg_idx == IRQ_ENABLE_IDX) begin
         ev_enable_q <= apb_req.pwdata[EV_WIDTH-1:0];
      end
   end

   // Interrupt outputs, registered from current state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bm_irq <= 1'b0;
         irq    <= 1'b0;
      end else begin
         bm_irq <= (rec_a_q.valid | rec_b_q.valid) & ~mask_q;      // [R17] [R04]
         irq    <= |(ev_status_q & ev_enable_q);
      end
   end

endmodule

// ### test/swdrop_checker.sv
// Port checker for the drop statistics block
`timescale 1ns/1ps
module swdrop_checker
   import swdrop_pkg::*;
(
   // Clock and reset
   input wire logic               pclk,
   input wire logic               presetn,
   // Bus
   input wire swdrop_apb_req_type apb_req,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   // Events and interrupts
   input wire swdrop_event_type   drop_event,
   input wire logic [2:0]         rate_drop,
   input wire logic               bm_irq,
   input wire logic               irq
);
   logic mask_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_take;
      apb_req.psel && apb_req.penable && !pready;
   endsequence
   sequence s_open_drop;
      !mask_q && drop_event.valid ##1 !mask_q;
   endsequence
   // Mask bit mirrored from bus writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mask_q <= 1'b1;
      else if (apb_req.psel && apb_req.penable && !pready && apb_req.pwrite
               && apb_req.paddr == {14'h0000, IRQ_MASK_IDX, 2'b00})
         mask_q <= apb_req.pwdata[0];
   end
   take_answer_a: assert property (s_take |=> pready) else $error("no answer");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
   ready_xfer_a: assert property (pready |-> apb_req.psel && apb_req.penable) else $error("stray ready");
   err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error reply");
   misalign_err_a: assert property (pready && apb_req.paddr[1:0] != 2'b00 |-> pslverr) else $error("misalign ok");
   high_addr_err_a: assert property (pready && apb_req.paddr[31:18] != 14'h0 |-> pslverr) else $error("high ok");
   masked_quiet_a: assert property (mask_q && $past(mask_q) |-> !bm_irq) else $error("masked irq");
   open_drop_a: assert property (s_open_drop |=> bm_irq) else $error("irq missing");
endmodule

bind swdrop_stats swdrop_checker u_chk (.pclk, .presetn, .apb_req, .prdata, .pready, .pslverr,
   .drop_event, .rate_drop, .bm_irq, .irq);

// ### test/swdrop_stats_tb_top.sv
// Self-checking bench for the drop statistics block
`timescale 1ns/1ps
module swdrop_stats_tb_top import swdrop_pkg::*;;
   logic               pclk;
   logic               presetn;
   swdrop_apb_req_type apb_req;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   swdrop_event_type   drop_event;
   logic [2:0]         rate_drop;
   logic               bm_irq;
   logic               irq;
   int                 errors;
   int                 checked;
   int                 cnt[3];
   logic [5:0]         q[$];
   logic [2:0]         st;
   logic [31:0]        seed;
   logic [31:0]        r;
   logic               e;
   logic [3:0]         codes[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
   logic [31:0]        bad[3] = '{32'h0000_7064, 32'h0000_7082, 32'h0004_7080};

   swdrop_stats u_dut (.pclk, .presetn, .apb_req, .prdata, .pready, .pslverr, .drop_event, .rate_drop,
      .bm_irq, .irq);

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] ad(input logic [15:0] i);
      return {14'h0, i, 2'b00};
   endfunction
   function automatic logic [31:0] pend();
      pend = 32'h0000_0000;
      foreach (q[k]) pend[7*k +: 7] = {q[k], 1'b1};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task automatic ev(input logic [3:0] c, input logic [1:0] p);
      @(posedge pclk);
      drop_event <= '{1'b1, swdrop_reason_type'(c), p};
      @(posedge pclk);
      drop_event.valid <= 1'b0;
      st[q.size() > 1] = 1'b1;
      if (q.size() < 2) q.push_back({c, p});
   endtask
   task automatic rdp();
      bus(1'b0, ad(IRQ_PENDING_IDX), 32'h0);
      chk(r, pend());
      q.delete();
   endtask
   task automatic irq_is(input logic v);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, {31'h0, v});
   endtask
   task automatic bm_is(input logic v);
      repeat (2) @(posedge pclk);
      chk({31'h0, bm_irq}, {31'h0, v});
   endtask
   task automatic conclude();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      conclude();
   end

   initial begin
      presetn = 1'b0;
      apb_req = '0;
      drop_event = '0;
      rate_drop = 3'h0;
      st = 3'h0;
      seed = 32'hda3e_dce0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      bus(1'b0, ad(IRQ_MASK_IDX), 32'h0);
      chk(r, 32'h0000_0001);
      foreach (bad[k]) begin
         bus(1'b0, bad[k], 32'h0);
         chk({31'h0, e}, 32'h1);
      end
      $display("done reset and errors");
      for (int i = 0; i < 60; i++) begin
         @(posedge pclk);
         seed = lfsr(seed);
         rate_drop <= seed[2:0];
         for (int p = 0; p < 3; p++) cnt[p] += seed[p];
      end
      @(posedge pclk);
      rate_drop <= 3'h0;
      for (int p = 0; p < 3; p++) begin
         bus(1'b0, ad(PORT0_DROP_CNT_IDX + 16'(p)), 32'h0);
         chk(r, cnt[p]);
         bus(1'b0, ad(PORT0_DROP_CNT_IDX + 16'(p)), 32'h0);
         chk(r, 32'h0000_0000);
      end
      $display("done counters");
      bus(1'b1, ad(IRQ_MASK_IDX), 32'hffff_fffe);
      bus(1'b0, ad(IRQ_MASK_IDX), 32'h0);
      chk(r, 32'h0000_0000);
      for (int k = 0; k < 8; k += 2) begin
         ev(codes[k], 2'(k % 3));
         ev(codes[k+1], 2'((k + 1) % 3));
         ev(4'h2, 2'h2);
         bm_is(1'b1);
         rdp();
         bm_is(1'b0);
      end
      bus(1'b1, ad(IRQ_MASK_IDX), 32'h1);
      ev(4'h9, 2'h1);
      bm_is(1'b0);
      rdp();
      $display("done records");
      bus(1'b0, ad(IRQ_STATUS_IDX), 32'h0);
      chk(r, {29'h0, st});
      bus(1'b1, ad(IRQ_CLEAR_IDX), 32'h7);
      bus(1'b1, ad(IRQ_ENABLE_IDX), 32'h1);
      irq_is(1'b0);
      ev(4'h1, 2'h0);
      irq_is(1'b1);
      rdp();
      bus(1'b1, ad(IRQ_CLEAR_IDX), 32'h1);
      irq_is(1'b0);
      $display("done interrupts");
      conclude();
   end
endmodule
